// file: drm_meter.sv
// Dual-slope resistance meter: port sequencing, capture and arithmetic.
`timescale 1ns/1ps
// Function
// - Drive whole port low before each charge.
// - Raise reference pin and start counter together.
// - Other port pins high impedance while charging.
// - Threshold crossing latches count, raises capture event.
// - Keep reference count, then discharge again.
// - Repeat sequence through the variable-charge pin.
// - Unknown resistance equals reference times count ratio.
// - Subtract series resistor to get sensor resistance.
// - Temperature from quadratic law around 25 degrees.
module drm_meter
  import drm_pkg::*;
#(
  parameter int unsigned PORT_WIDTH    = drm_pkg::PORT_W,
  parameter int unsigned CNT_WIDTH     = drm_pkg::CNT_W,
  parameter int unsigned PRESCALE_DIV  = drm_pkg::PRESCALE,
  parameter int unsigned DISCHARGE_CYC = drm_pkg::DISCHARGE_CYC,
  parameter int unsigned REF_OHMS      = drm_pkg::REF_OHM,
  parameter int unsigned SERIES_OHMS   = drm_pkg::SERIES_OHM,
  parameter int unsigned R25_OHMS      = drm_pkg::R25_OHM
) (
  input  wire logic                  clk_i,
  input  wire logic                  rst_i,
  input  wire logic                  clk_en_i,
  input  wire logic                  start_i,
  input  wire logic                  capture_sense_i,
  output logic [PORT_WIDTH-1:0]      port_o,
  output logic [PORT_WIDTH-1:0]      port_oe_n_o,
  output logic [CNT_WIDTH-1:0]       reference_charge_count_o,
  output logic [CNT_WIDTH-1:0]       variable_charge_count_o,
  output logic [31:0]                unknown_resistance_o,
  output logic [31:0]                sensor_resistance_o,
  output logic signed [15:0]         temperature_o,
  output logic                       capture_o,
  output logic                       busy_o,
  output logic                       done_o,
  output logic                       error_o
);

  import drm_pkg::*;

  localparam logic [CNT_WIDTH-1:0] CNT_MAX = {CNT_WIDTH{1'b1}};
  localparam logic [15:0] PRE_LAST  = 16'(PRESCALE_DIV - 1);
  localparam logic [31:0] DIS_LAST  = 32'(DISCHARGE_CYC - 1);

  drm_state_e              state_q, state_d;   // Sequence state.
  logic [PORT_WIDTH-1:0]   port_q, port_d;     // Pin output levels.
  logic [PORT_WIDTH-1:0]   oe_n_q, oe_n_d;     // Pin enables, low drives.
  logic [2:0]              sync_q, sync_d;     // Three-stage pin sync.
  logic                    lvl_q, lvl_d;       // Debounced sense level.
  logic [15:0]             pre_q, pre_d;       // Timer prescaler.
  logic [CNT_WIDTH-1:0]    cnt_q, cnt_d;       // Charge-time counter.
  logic [31:0]             dis_q, dis_d;       // Discharge timer.
  logic [CNT_WIDTH-1:0]    reference_charge_count_q, reference_charge_count_d;     // Reference count.
  logic [CNT_WIDTH-1:0]    variable_charge_count_q, variable_charge_count_d;     // Variable count.
  logic [31:0]             unknown_resistance_q, unknown_resistance_d;     // Unknown resistance.
  logic [31:0]             rsen_q, rsen_d;     // Sensor resistance.
  logic [TEMP_W-1:0]       tcode_q, tcode_d;   // Search code.
  logic [3:0]              tbit_q, tbit_d;     // Search bit index.
  logic signed [15:0]      temp_q, temp_d;     // Temperature, 1/16 C.
  logic                    cap_q, cap_d;       // Capture event pulse.
  logic                    done_q, done_d;     // Completion pulse.
  logic                    err_q, err_d;       // Sticky abort flag.
  logic                    busy_q, busy_d;     // Sequence running.
  logic                    div_start;          // Divider launch.
  logic                    div_done;           // Divider finished.
  logic [31:0]             div_quo;            // Divider result.
  logic [31:0]             div_num;            // Reference times count.

  // The ratio is formed as (Reference_resistance * variable_charge_count) / reference_charge_count in one divide.
  assign div_num   = 32'(REF_OHMS) * 32'(variable_charge_count_q);
  assign div_start = (state_q == ST_DIV_GO);

  drm_div #(
    .W (32)
  ) u_div (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .en_i    (clk_en_i),
    .start_i (div_start),
    .num_i   (div_num),
    .den_i   ({{(32-CNT_WIDTH){1'b0}}, reference_charge_count_q}),
    .done_o  (div_done),
    .quo_o   (div_quo)
  );

  // Next-state logic for the whole measurement sequence.
  always_comb begin
    logic                rise;
    logic                tick;
    logic [TEMP_W-1:0]   trial;
    logic signed [63:0]  dq;
    logic signed [63:0]  law;
    logic signed [63:0]  lhs;
    rise    = 1'b0;
    tick    = 1'b0;
    trial   = '0;
    dq      = '0;
    law     = '0;
    lhs     = '0;
    state_d = state_q;
    port_d  = port_q;
    oe_n_d  = oe_n_q;
    pre_d   = pre_q;
    cnt_d   = cnt_q;
    dis_d   = dis_q;
    reference_charge_count_d  = reference_charge_count_q;
    variable_charge_count_d  = variable_charge_count_q;
    unknown_resistance_d  = unknown_resistance_q;
    rsen_d  = rsen_q;
    tcode_d = tcode_q;
    tbit_d  = tbit_q;
    temp_d  = temp_q;
    err_d   = err_q;
    cap_d   = 1'b0;
    done_d  = 1'b0;

    // The first stage feeds only the second; the level moves once the
    // second and third stages agree, which rejects a single glitch.
    sync_d = {sync_q[1:0], capture_sense_i};
    lvl_d  = (sync_q[1] == sync_q[2]) ? sync_q[2] : lvl_q;
    rise   = (sync_q[1] == sync_q[2]) && sync_q[2] && !lvl_q;

    // Prescaled timer tick; the prescaler restarts with each charge.
    if (pre_q == PRE_LAST) begin
      pre_d = 16'h0000;
      tick  = 1'b1;
    end else begin
      pre_d = pre_q + 16'h0001;
    end

    case (state_q)
      ST_IDLE: begin
        if (start_i) begin
          // Whole port low and driven, so the capacitor empties.
          port_d  = '0;
          oe_n_d  = '0;
          dis_d   = 32'h0000_0000;
          err_d   = 1'b0;
          state_d = ST_DIS_REF;
        end
      end
      ST_DIS_REF, ST_DIS_VAR: begin
        dis_d = dis_q + 32'h0000_0001;
        if (dis_q == DIS_LAST) begin
          // Raise one charge pin and float every other pin in the same
          // edge as the counter restarts, so timing begins exactly here.
          port_d = '0;
          oe_n_d = '1;
          if (state_q == ST_DIS_REF) begin
            port_d[REF_IDX] = 1'b1;
            oe_n_d[REF_IDX] = 1'b0;
            state_d         = ST_CHG_REF;
          end else begin
            port_d[VAR_IDX] = 1'b1;
            oe_n_d[VAR_IDX] = 1'b0;
            state_d         = ST_CHG_VAR;
          end
          cnt_d = '0;
          pre_d = 16'h0000;
        end
      end
      ST_CHG_REF, ST_CHG_VAR: begin
        if (rise) begin
          // Threshold crossed: latch the running count, pulse capture and discharge.
          cap_d = 1'b1;
          if (state_q == ST_CHG_REF) begin
            reference_charge_count_d  = cnt_q;
            state_d = ST_DIS_VAR;
          end else begin
            variable_charge_count_d  = cnt_q;
            state_d = ST_DIV_GO;
          end
          port_d = '0;
          oe_n_d = '0;
          dis_d  = 32'h0000_0000;
        end else if (tick) begin
          if (cnt_q == CNT_MAX) begin
            // No crossing before wrap: the count would be meaningless,
            // so discharge, give up and report rather than reuse it.
            err_d   = 1'b1;
            port_d  = '0;
            oe_n_d  = '0;
            state_d = ST_FINISH;
          end else begin
            cnt_d = cnt_q + CNT_WIDTH'(1'b1);
          end
        end
      end
      ST_DIV_GO: begin
        // A zero reference count cannot be divided; treat as failure.
        if (reference_charge_count_q == '0) begin
          err_d   = 1'b1;
          state_d = ST_FINISH;
        end else begin
          state_d = ST_DIV_WAIT;
        end
      end
      ST_DIV_WAIT: begin
        if (div_done) begin
          unknown_resistance_d  = div_quo;
          state_d = ST_SERIES;
        end
      end
      ST_SERIES: begin
        // Clamp at zero: a short sensor must not wrap to a huge value.
        if (unknown_resistance_q > 32'(SERIES_OHMS)) begin
          rsen_d = unknown_resistance_q - 32'(SERIES_OHMS);
        end else begin
          rsen_d = 32'h0000_0000;
        end
        tcode_d = '0;
        tbit_d  = 4'(TEMP_W - 1);
        state_d = ST_TEMP;
      end
      ST_TEMP: begin
        // Binary search for the largest offset whose law value stays at
        // or below the measured ratio; the law rises over this range,
        // which avoids a square root at the cost of twelve cycles.
        trial        = tcode_q;
        trial[tbit_q] = 1'b1;
        dq  = 64'(signed'({1'b0, trial})) - 64'(signed'(TEMP_MID));
        law = LAW_ONE + COEF_A * dq + COEF_B * dq * dq;
        lhs = 64'(signed'({1'b0, rsen_q})) <<< LAW_SHIFT;
        if (law * 64'(R25_OHMS) <= lhs) begin
          tcode_d = trial;
        end
        if (tbit_q == 4'h0) begin
          state_d = ST_FINISH;
        end else begin
          tbit_d = tbit_q - 4'h1;
        end
      end
      ST_FINISH: begin
        // Result in 1/16 C: reference temperature plus the offset.
        if (!err_q) begin
          temp_d = signed'(TEMP_REF_Q) +
                   signed'(16'(tcode_q)) - signed'(16'(TEMP_MID));
        end
        done_d  = 1'b1;
        state_d = ST_IDLE;
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase

    // Busy follows the next state, so its flop matches the state flop.
    busy_d = (state_d != ST_IDLE);
  end

  // State registers; a low clock enable freezes the whole block.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_q <= ST_IDLE;
      port_q  <= '0;
      oe_n_q  <= '0;
      sync_q  <= 3'h0;
      lvl_q   <= 1'b0;
      pre_q   <= 16'h0000;
      cnt_q   <= '0;
      dis_q   <= 32'h0000_0000;
      reference_charge_count_q  <= '0;
      variable_charge_count_q  <= '0;
      unknown_resistance_q  <= 32'h0000_0000;
      rsen_q  <= 32'h0000_0000;
      tcode_q <= '0;
      tbit_q  <= 4'h0;
      temp_q  <= 16'sh0000;
      cap_q   <= 1'b0;
      done_q  <= 1'b0;
      err_q   <= 1'b0;
      busy_q  <= 1'b0;
    end else if (clk_en_i) begin
      state_q <= state_d;
      port_q  <= port_d;
      oe_n_q  <= oe_n_d;
      sync_q  <= sync_d;
      lvl_q   <= lvl_d;
      pre_q   <= pre_d;
      cnt_q   <= cnt_d;
      dis_q   <= dis_d;
      reference_charge_count_q  <= reference_charge_count_d;
      variable_charge_count_q  <= variable_charge_count_d;
      unknown_resistance_q  <= unknown_resistance_d;
      rsen_q  <= rsen_d;
      tcode_q <= tcode_d;
      tbit_q  <= tbit_d;
      temp_q  <= temp_d;
      cap_q   <= cap_d;
      done_q  <= done_d;
      err_q   <= err_d;
      busy_q  <= busy_d;
    end
  end

  // Every output is a flip-flop, so no decode glitch reaches a pin.
  assign port_o                   = port_q;
  assign port_oe_n_o              = oe_n_q;
  assign reference_charge_count_o = reference_charge_count_q;
  assign variable_charge_count_o  = variable_charge_count_q;
  assign unknown_resistance_o     = unknown_resistance_q;
  assign sensor_resistance_o      = rsen_q;
  assign temperature_o            = temp_q;
  assign capture_o                = cap_q;
  assign done_o                   = done_q;
  assign error_o                  = err_q;
  assign busy_o                   = busy_q;

endmodule

// file: drm_pkg.sv
// Shared constants for the dual-slope resistance meter.
package drm_pkg;

  // Clock period of the controller clock in nanoseconds.
  localparam int unsigned CLK_PERIOD_NS = 10;

  // Discharge time before each charge phase, in nanoseconds.
  localparam int unsigned DISCHARGE_NS  = 100000;
  // Discharge time as clock cycles, at least one cycle.
  localparam int unsigned DISCHARGE_CYC =
    (DISCHARGE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Width of the measurement port and the roles of its pins.
  localparam int unsigned PORT_W      = 8;
  localparam int unsigned CAPTURE_IDX = 0;
  localparam int unsigned REF_IDX     = 2;
  localparam int unsigned VAR_IDX     = 3;

  // Timer width and the default prescaler of the charge-time counter.
  localparam int unsigned CNT_W    = 16;
  localparam int unsigned PRESCALE = 8;

  // Default resistances in ohms.
  localparam int unsigned REF_OHM    = 10000;
  localparam int unsigned SERIES_OHM = 1000;
  localparam int unsigned R25_OHM    = 1970;

  // Quadratic sensor law, coefficients as printed.
  localparam real ALPHA_PER_K  = 7.88e-3;
  localparam real BETA_PER_K2  = 1.937e-5;
  localparam int  REF_TEMP_C   = 25;

  // Fixed point: temperature step is 1/16 K, law scaled by 2^32.
  localparam int unsigned    TEMP_FRAC = 4;
  localparam int unsigned    TEMP_W    = 12;
  localparam int unsigned    LAW_SHIFT = 32;
  localparam longint         LAW_ONE   = 64'sh0000_0001_0000_0000;
  localparam longint         COEF_A    =
    longint'(ALPHA_PER_K * 4294967296.0 / 16.0);
  localparam longint         COEF_B    =
    longint'(BETA_PER_K2 * 4294967296.0 / 256.0);
  // Search offset: code 2048 stands for the reference temperature.
  localparam logic [12:0]    TEMP_MID  = 13'h0800;
  localparam logic [15:0]    TEMP_REF_Q =
    16'(REF_TEMP_C * (1 << TEMP_FRAC));

  // Measurement sequence states.
  typedef enum logic [3:0] {
    ST_IDLE     = 4'b0000,
    ST_DIS_REF  = 4'b0001,
    ST_CHG_REF  = 4'b0010,
    ST_DIS_VAR  = 4'b0011,
    ST_CHG_VAR  = 4'b0100,
    ST_DIV_GO   = 4'b0101,
    ST_DIV_WAIT = 4'b0110,
    ST_SERIES   = 4'b0111,
    ST_TEMP     = 4'b1000,
    ST_FINISH   = 4'b1001
  } drm_state_e;

endpackage

// file: drm_div.sv
// Unsigned restoring divider used for the resistance ratio.
`timescale 1ns/1ps
module drm_div #(
  parameter int unsigned W = 32
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic         en_i,
  input  wire logic         start_i,
  input  wire logic [W-1:0] num_i,
  input  wire logic [W-1:0] den_i,
  output logic              done_o,
  output logic [W-1:0]      quo_o
);

  logic         busy_q, busy_d;   // Division in progress.
  logic [7:0]   cnt_q, cnt_d;     // Remaining quotient bits.
  logic [W-1:0] num_q, num_d;     // Dividend, shifted out at the top.
  logic [W-1:0] den_q, den_d;     // Divisor, held for the run.
  logic [W:0]   rem_q, rem_d;     // Partial remainder, one spare bit.
  logic [W-1:0] quo_q, quo_d;     // Quotient, shifted in at the bottom.
  logic         done_q, done_d;   // One-cycle completion pulse.

  // One quotient bit per cycle; slow but tiny, and time is plentiful.
  always_comb begin
    logic [W:0] trial;
    trial  = '0;
    busy_d = busy_q;
    cnt_d  = cnt_q;
    num_d  = num_q;
    den_d  = den_q;
    rem_d  = rem_q;
    quo_d  = quo_q;
    done_d = 1'b0;
    if (start_i && !busy_q) begin
      // Load a fresh operand pair.
      busy_d = 1'b1;
      cnt_d  = 8'(W);
      num_d  = num_i;
      den_d  = den_i;
      rem_d  = '0;
      quo_d  = '0;
    end else if (busy_q) begin
      // Shift in the next dividend bit and try a subtraction.
      trial = {rem_q[W-1:0], num_q[W-1]};
      num_d = {num_q[W-2:0], 1'b0};
      if (trial >= {1'b0, den_q}) begin
        rem_d = trial - {1'b0, den_q};
        quo_d = {quo_q[W-2:0], 1'b1};
      end else begin
        rem_d = trial;
        quo_d = {quo_q[W-2:0], 1'b0};
      end
      cnt_d = cnt_q - 8'h01;
      if (cnt_q == 8'h01) begin
        busy_d = 1'b0;
        done_d = 1'b1;
      end
    end
  end

  // Registers only; the clock enable freezes everything.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      busy_q <= 1'b0;
      cnt_q  <= 8'h00;
      num_q  <= '0;
      den_q  <= '0;
      rem_q  <= '0;
      quo_q  <= '0;
      done_q <= 1'b0;
    end else if (en_i) begin
      busy_q <= busy_d;
      cnt_q  <= cnt_d;
      num_q  <= num_d;
      den_q  <= den_d;
      rem_q  <= rem_d;
      quo_q  <= quo_d;
      done_q <= done_d;
    end
  end

  assign done_o = done_q;
  assign quo_o  = quo_q;

endmodule

// file: drm_meter_checker.sv
// Concurrent checks on the ports of the resistance meter.
`timescale 1ns/1ps
module drm_meter_checker #(
  parameter int unsigned PORT_WIDTH  = 8,
  parameter int unsigned CNT_WIDTH   = 16,
  parameter int unsigned REF_OHMS    = 10000,
  parameter int unsigned SERIES_OHMS = 1000
) (
  input wire logic                  clk_i,
  input wire logic                  rst_i,
  input wire logic                  clk_en_i,
  input wire logic                  start_i,
  input wire logic [PORT_WIDTH-1:0] port_o,
  input wire logic [PORT_WIDTH-1:0] port_oe_n_o,
  input wire logic [CNT_WIDTH-1:0]  reference_charge_count_o,
  input wire logic [CNT_WIDTH-1:0]  variable_charge_count_o,
  input wire logic [31:0]           unknown_resistance_o,
  input wire logic [31:0]           sensor_resistance_o,
  input wire logic signed [15:0]    temperature_o,
  input wire logic                  capture_o,
  input wire logic                  busy_o,
  input wire logic                  done_o,
  input wire logic                  error_o
);
  // Single clock domain, so clock and reset are given once here.
  default clocking dc @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // Products for the ratio check, widened so nothing overflows.
  logic [63:0] lhs_w;
  logic [63:0] rhs_w;
  assign lhs_w = 64'(unknown_resistance_o) * 64'(reference_charge_count_o);
  assign rhs_w = 64'(REF_OHMS) * 64'(variable_charge_count_o);

  a_drive_low: assert property (port_oe_n_o == '0 |-> port_o == '0)
    else $error("Driven port pins are not all low.");
  a_ref_hiz: assert property (
    port_oe_n_o == 8'hFB |-> port_o == 8'h04)
    else $error("Reference charge pattern is wrong.");
  a_var_hiz: assert property (
    port_oe_n_o == 8'hF7 |-> port_o == 8'h08)
    else $error("Variable charge pattern is wrong.");
  a_oe_legal: assert property (
    port_oe_n_o inside {8'h00, 8'hFB, 8'hF7})
    else $error("Illegal enable pattern on the port.");
  a_dis_first: assert property (
    $changed(port_oe_n_o) && port_oe_n_o != '0
    |-> $past(port_oe_n_o) == '0)
    else $error("Charge began without a discharge.");
  a_capture_dis: assert property (
    capture_o |-> port_oe_n_o == '0 && $past(port_oe_n_o) != '0)
    else $error("Capture outside a charge or no discharge.");
  a_done_pulse: assert property (
    done_o && clk_en_i |=> !done_o && !busy_o)
    else $error("Done is not a single pulse ending busy.");
  // The abort flag rises as the sequence enters its finish state, so
  // the done pulse follows one cycle later.
  a_abort_flag: assert property (
    $rose(error_o) |-> port_oe_n_o == '0 ##1 done_o)
    else $error("Abort did not finish and discharge.");
  a_ratio_floor: assert property (
    done_o && !error_o
    |-> lhs_w <= rhs_w && lhs_w + 64'(reference_charge_count_o) > rhs_w)
    else $error("Resistance is not the floor of the ratio.");
  a_series_sub: assert property (
    done_o && !error_o && unknown_resistance_o >= SERIES_OHMS
    |-> sensor_resistance_o == unknown_resistance_o - SERIES_OHMS)
    else $error("Series resistor not subtracted.");
  a_temp_only_ok: assert property (
    !$stable(temperature_o) |-> done_o && !error_o)
    else $error("Temperature changed outside a clean finish.");
  a_start_taken: assert property (
    start_i && clk_en_i && !busy_o |=> busy_o [*2])
    else $error("Start in idle was not taken.");

  c_capture: cover property (capture_o);
  c_ok_done: cover property (done_o && !error_o);
  c_err_done: cover property (done_o && error_o);
endmodule

bind drm_meter drm_meter_checker #(
  .PORT_WIDTH(PORT_WIDTH), .CNT_WIDTH(CNT_WIDTH),
  .REF_OHMS(REF_OHMS), .SERIES_OHMS(SERIES_OHMS)
) u_checker (
  .clk_i(clk_i), .rst_i(rst_i), .clk_en_i(clk_en_i), .start_i(start_i),
  .port_o(port_o), .port_oe_n_o(port_oe_n_o),
  .reference_charge_count_o(reference_charge_count_o),
  .variable_charge_count_o(variable_charge_count_o),
  .unknown_resistance_o(unknown_resistance_o),
  .sensor_resistance_o(sensor_resistance_o),
  .temperature_o(temperature_o), .capture_o(capture_o), .busy_o(busy_o),
  .done_o(done_o), .error_o(error_o)
);

// file: drm_rc_model.sv
// Behavioural RC network: timing capacitor, charge resistors, sense pin.
`timescale 1ns/1ps
module drm_rc_model (
  input  wire logic        clk_i,
  input  wire logic [7:0]  port_i,
  input  wire logic [7:0]  port_oe_n_i,
  input  wire logic [31:0] ref_cyc_i,
  input  wire logic [31:0] var_cyc_i,
  output logic             sense_o
);
  logic [31:0] charge_q = '0;           // Charge held, in clock cycles.
  logic [31:0] thr_q    = 32'hFFFFFFFF; // Cycles to reach the threshold.
  logic        dis_w;                   // Capture pin pulls the cap low.
  logic        ref_w;                   // Charging through reference.
  logic        var_w;                   // Charging through the sensor.

  assign dis_w = !port_oe_n_i[0] && !port_i[0];
  assign ref_w = port_oe_n_i[0] && !port_oe_n_i[2] && port_i[2];
  assign var_w = port_oe_n_i[0] && !port_oe_n_i[3] && port_i[3];

  // The cap only charges while the capture pin floats; a charge time
  // above the counter range models a broken sensor that never trips.
  always @(posedge clk_i) begin
    if (dis_w) begin
      charge_q <= '0;
    end else if (ref_w || var_w) begin
      charge_q <= charge_q + 32'h1;
    end
    if (ref_w) begin
      thr_q <= ref_cyc_i;
    end else if (var_w) begin
      thr_q <= var_cyc_i;
    end
  end

  // A driven capture pin shows its own level; a floating one the cap.
  assign sense_o = !port_oe_n_i[0] ? port_i[0] : (charge_q >= thr_q);
endmodule

// file: test_drm_meter.sv
// Self-checking bench for the dual-slope resistance meter.
`timescale 1ns/1ps
module test_drm_meter;
  import drm_pkg::*;
  localparam int unsigned RO = 10000; // Reference resistor in ohms.
  localparam int unsigned SO = 1000;  // Series resistor in ohms.
  typedef struct {logic err; int unsigned rc; int unsigned vc;} drm_note_s;
  logic               clk_i, rst_i, start_i, sense, cap, busy, done, err;
  logic               clk_en; // Clock enable, lowered to freeze the block.
  logic [7:0]         port_w, oe_n_w;
  logic [15:0]        rcnt, vcnt;
  logic [31:0]        unk, sens, ref_cyc, var_cyc, seed;
  logic signed [15:0] temp;
  int unsigned        failures, tests_run, caps;
  drm_note_s          notes[$]; // Expected outcomes, oldest first.

  // Short discharge and no prescaler keep the run brief.
  drm_meter #(.DISCHARGE_CYC(8), .PRESCALE_DIV(1), .REF_OHMS(RO),
    .SERIES_OHMS(SO)) dut (
    .clk_i(clk_i), .rst_i(rst_i), .clk_en_i(clk_en), .start_i(start_i),
    .capture_sense_i(sense), .port_o(port_w), .port_oe_n_o(oe_n_w),
    .reference_charge_count_o(rcnt), .variable_charge_count_o(vcnt),
    .unknown_resistance_o(unk), .sensor_resistance_o(sens),
    .temperature_o(temp), .capture_o(cap), .busy_o(busy), .done_o(done),
    .error_o(err));

  drm_rc_model u_rc (.clk_i(clk_i), .port_i(port_w), .port_oe_n_i(oe_n_w),
    .ref_cyc_i(ref_cyc), .var_cyc_i(var_cyc), .sense_o(sense));

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  // Xorshift generator for charge times.
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("BAD t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask

  // Range compare, for values that carry sync latency or rounding.
  task automatic rng(input logic signed [63:0] got, input longint lo,
                     input longint hi);
    tests_run++;
    if ((got >= lo && got <= hi) !== 1'b1) begin
      failures++;
      $display("BAD t=%0t got=%0h exp=%0h..%0h", $time, got, lo, hi);
    end
  endtask

  // One measurement; poke raises start again while busy, which must
  // be ignored without disturbing the sequence.
  task automatic measure(input int unsigned rc, input int unsigned vc,
                         input logic poke);
    @(negedge clk_i);
    ref_cyc = rc;
    var_cyc = vc;
    notes.push_back('{(vc > 60000), rc, vc});
    start_i = 1'b1;
    @(negedge clk_i);
    start_i = 1'b0;
    if (poke) begin
      repeat (20) @(negedge clk_i);
      start_i = 1'b1;
      @(negedge clk_i);
      start_i = 1'b0;
    end
    for (int i = 0; i < 70000 && busy !== 1'b0; i++) @(negedge clk_i);
  endtask

  // Judges one finished measurement against the oldest note.
  task automatic check_done();
    drm_note_s n;
    real       kt;
    real       t;
    longint    e16;
    longint    eu;
    n = notes.pop_front();
    chk(err, n.err);
    chk(caps, n.err ? 1 : 2);
    caps = 0;
    if (!n.err) begin
      rng({48'h0, rcnt}, n.rc, n.rc + 6);
      rng({48'h0, vcnt}, n.vc, n.vc + 6);
      eu = longint'(RO) * longint'(vcnt) / longint'(rcnt);
      chk(unk, eu);
      chk(sens, eu - SO);
      kt = real'(eu - SO) / real'(R25_OHM);
      t = 25.0 + ($sqrt(ALPHA_PER_K * ALPHA_PER_K - 4.0 * BETA_PER_K2
          + 4.0 * BETA_PER_K2 * kt) - ALPHA_PER_K) / (2.0 * BETA_PER_K2);
      e16 = longint'($floor(t * 16.0));
      rng(temp, e16 - 1, e16 + 1);
    end
  endtask

  // Monitor: counts capture events and takes a note off at each done.
  always @(negedge clk_i) begin
    if (cap === 1'b1) caps++;
    // A done pulse with no note pending is itself a mismatch.
    if (done === 1'b1) begin
      if (notes.size() > 0) check_done();
      else chk(0, 1);
    end
  end

  task automatic close_out();
    $display("Comparisons %0d, mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Watchdog sized above the overflow run plus the normal ones.
  initial begin
    #(90000 * 10);
    failures++;
    close_out();
  end

  initial begin
    int unsigned rc;
    rst_i = 1'b1;
    clk_en = 1'b1;
    start_i = 1'b0;
    ref_cyc = 1000;
    var_cyc = 300;
    seed = 32'h592F;
    failures = 0;
    tests_run = 0;
    caps = 0;
    repeat (8) @(posedge clk_i);
    @(negedge clk_i);
    rst_i = 1'b0;
    chk(oe_n_w, 8'h00);
    chk(port_w, 8'h00);
    chk(busy, 1'b0);
    measure(800, 240, 1'b1);
    for (int i = 0; i < 5; i++) begin
      seed = xs(seed);
      rc = 600 + seed % 400;
      seed = xs(seed);
      measure(rc, rc * (20 + seed % 30) / 100, 1'b0);
    end
    measure(900, 100000, 1'b0);
    // A frozen block must ignore start and keep its abort flag.
    @(negedge clk_i);
    clk_en = 1'b0;
    start_i = 1'b1;
    repeat (6) @(negedge clk_i);
    chk(busy, 1'b0);
    chk(err, 1'b1);
    chk(oe_n_w, 8'h00);
    start_i = 1'b0;
    clk_en = 1'b1;
    measure(1000, 450, 1'b0);
    repeat (4) @(negedge clk_i);
    chk(notes.size(), 0);
    close_out();
  end
endmodule
